// ==== pkg/acra_pkg.sv ====
// Shared constants and types of the customer register array
package acra_pkg;

  // ----------------------------------------
  // Register addresses
  // ----------------------------------------
  localparam logic [7:0] ADDR_SERIAL0 = 8'h00;
  localparam logic [7:0] ADDR_SERIAL3 = 8'h03;
  localparam logic [7:0] ADDR_RSVD_F04 = 8'h04;
  localparam logic [7:0] ADDR_RSVD_F05 = 8'h05;
  localparam logic [7:0] ADDR_FACT_X = 8'h06;
  localparam logic [7:0] ADDR_FACT_Y = 8'h07;
  localparam logic [7:0] ADDR_PART_CODE = 8'h08;
  localparam logic [7:0] ADDR_UNASSIGNED = 8'h09;
  localparam logic [7:0] ADDR_DEV_CTRL = 8'h0a;
  localparam logic [7:0] ADDR_DEV_CFG = 8'h0b;
  localparam logic [7:0] ADDR_AXIS_X = 8'h0c;
  localparam logic [7:0] ADDR_AXIS_Y = 8'h0d;
  localparam logic [7:0] ADDR_ARM_CFG_X = 8'h0e;
  localparam logic [7:0] ADDR_ARM_CFG_Y = 8'h0f;
  localparam logic [7:0] ADDR_THR_XP = 8'h10;
  localparam logic [7:0] ADDR_THR_YP = 8'h11;
  localparam logic [7:0] ADDR_THR_XN = 8'h12;
  localparam logic [7:0] ADDR_THR_YN = 8'h13;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_COUNTER = 8'h15;
  localparam logic [7:0] ADDR_OFFSET_X = 8'h16;
  localparam logic [7:0] ADDR_OFFSET_Y = 8'h17;
  localparam logic [7:0] ADDR_RSVD_U1C = 8'h1c;
  localparam logic [7:0] ADDR_RSVD_U1D = 8'h1d;

  // ----------------------------------------
  // Field positions and sizes
  // ----------------------------------------
  localparam int OTP_BYTES = 9;
  localparam int WR_BYTES = 9;
  localparam int SERIAL_COUNT_BITS = 13;
  localparam int SELFTEST_MAG_BIT = 7;
  localparam int INIT_LOCK_BIT = 5;
  localparam int RESET_CODE_HIGH_BIT = 7;
  localparam int RESET_CODE_LOW_BIT = 6;
  localparam int STATUS_DEVRES_BIT = 0;
  localparam logic [7:0] DEV_CFG_WMASK = 8'h3f;
  localparam logic [7:0] AXIS_CFG_WMASK = 8'h8f;
  localparam logic [7:0] ARM_CFG_WMASK = 8'h3f;
  localparam logic [7:0] STATUS_IN_MASK = 8'h7e;
  localparam logic [7:0] RESET_VALUE = 8'h00;
  localparam logic [7:0] CRC_POLY = 8'h2f;
  localparam logic [7:0] CRC_INIT = 8'hff;

  // Reset code pairs, high bit first
  localparam logic [1:0] RESET_CODE_FIRST = 2'h0;
  localparam logic [1:0] RESET_CODE_SECOND = 2'h3;
  localparam logic [1:0] RESET_CODE_THIRD = 2'h1;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_GOT_FIRST, SEQ_GOT_SECOND} acra_seq_e;

  typedef struct packed {
    logic [7:0] device_config;
    logic [7:0] axisX;
    logic [7:0] axisY;
    logic [7:0] armX;
    logic [7:0] armY;
    logic [7:0] thrXp;
    logic [7:0] thrYp;
    logic [7:0] thrXn;
    logic [7:0] thrYn;
  } acra_cfg_s;

  typedef struct packed {
    logic [7:0] counter;
    logic [7:0] offsetX;
    logic [7:0] offsetY;
    logic [7:0] status;
  } acra_sense_s;

endpackage

// ==== design/acra_crc8.sv ====
// CRC-8 over a block of bytes, byte 0 first
`timescale 1ns/1ns
`default_nettype none
module acra_crc8 import acra_pkg::*; #(
  parameter int NBYTES = 9
) (
  input wire logic [NBYTES-1:0][7:0] blockData, // Bytes to cover
  output logic [7:0] crcValue // Combinational CRC result
);

  // ----------------------------------------
  // Byte-serial CRC chain
  // ----------------------------------------
  // One entry per stage, so each generate branch drives its own element
  logic [7:0] chain [NBYTES+1];

  assign chain[0] = CRC_INIT;

  genvar gi;
  generate
    for (gi = 0; gi < NBYTES; gi++) begin : g_byte
      always_comb begin
        logic [7:0] acc;
        acc = chain[gi] ^ blockData[gi];
        for (int b = 0; b < 8; b++) begin
          acc = acc[7] ? ({acc[6:0], 1'b0} ^ CRC_POLY) : {acc[6:0], 1'b0};
        end
        chain[gi+1] = acc;
      end
    end
  endgenerate

  assign crcValue = chain[NBYTES];

endmodule
`default_nettype wire

// ==== design/acra_reset_seq.sv ====
// Three-write device reset sequence detector
`timescale 1ns/1ns
`default_nettype none
module acra_reset_seq import acra_pkg::*; (
  input wire logic clk, // System clock
  input wire logic sys_rst, // Synchronous reset, active high
  input wire logic cmdValid, // Any register command this cycle
  input wire logic ctrlWrite, // Command is a write to device control
  input wire logic [1:0] resetCode, // High and low reset code bits written
  output logic resetPulse // One-cycle device reset request
);

  // ----------------------------------------
  // Sequence state
  // ----------------------------------------
  acra_seq_e seq_reg, seq_next;
  logic pulse_reg, pulse_next;

  always_comb begin
    seq_next = seq_reg;
    pulse_next = 1'b0;
    if (cmdValid) begin
      // Any other command aborts; a first code always restarts
      seq_next = SEQ_IDLE;
      if (ctrlWrite) begin
        case (seq_reg)
          SEQ_GOT_FIRST: begin
            if (resetCode == RESET_CODE_SECOND) seq_next = SEQ_GOT_SECOND;
          end
          SEQ_GOT_SECOND: begin
            if (resetCode == RESET_CODE_THIRD) pulse_next = 1'b1;
          end
          default: begin
          end
        endcase
        if (resetCode == RESET_CODE_FIRST) seq_next = SEQ_GOT_FIRST;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      seq_reg <= SEQ_IDLE;
      pulse_reg <= 1'b0;
    end else begin
      seq_reg <= seq_next;
      pulse_reg <= pulse_next;
    end
  end

  assign resetPulse = pulse_reg;

endmodule
`default_nettype wire

// ==== design/acra_register_array.sv ====
// Customer register array: factory shadow, writable configuration, status
`timescale 1ns/1ns
`default_nettype none
module acra_register_array import acra_pkg::*; (
  input wire logic clk, // System clock, 100 MHz
  input wire logic sys_rst, // Synchronous reset, active high
  input wire logic [OTP_BYTES-1:0][7:0] otpImage, // Fuse array, byte 0 at address 0
  input wire logic [7:0] otpCrcRef, // Stored CRC of the fuse array
  input wire acra_sense_s senseIn, // Live status, counter and offset values
  input wire logic regValid, // One-cycle register command strobe
  input wire logic regWrite, // Command is a write
  input wire logic [7:0] regAddr, // Register address
  input wire logic [7:0] regWrData, // Write data
  output logic regAck, // Answer strobe, one cycle
  output logic [7:0] regRdData, // Read data, zero for writes
  output logic regInvalid, // Invalid register request, with regAck
  output acra_cfg_s cfgOut, // Writable configuration contents
  output logic [1:0] selftestHigh, // Per axis: high self-test deflection
  output logic [31:0] serialNumber, // Whole device serial number
  output logic [7:0] partCode, // Part code byte
  output logic initLocked, // Init-done lock engaged
  output logic otpCrcFault, // Factory block CRC mismatch
  output logic wrCrcFault, // Writable block CRC mismatch
  output logic deviceReset // One-cycle internal device reset
);

  // ----------------------------------------
  // Factory shadow
  // ----------------------------------------
  logic [OTP_BYTES-1:0][7:0] shadow_reg, shadow_next;
  logic loadPending_reg, loadPending_next;

  // ----------------------------------------
  // Writable block and status
  // ----------------------------------------
  acra_cfg_s cfg_reg, cfg_next;
  logic [7:0] wrCrcRef_reg, wrCrcRef_next;
  logic devResFlag_reg, devResFlag_next;
  logic otpFault_reg, otpFault_next;
  logic wrFault_reg, wrFault_next;
  logic lockArmed_reg, lockArmed_next;

  // ----------------------------------------
  // Answer path
  // ----------------------------------------
  logic ack_reg, ack_next;
  logic [7:0] rdData_reg, rdData_next;
  logic invalid_reg, invalid_next;

  // ----------------------------------------
  // Sub-blocks
  // ----------------------------------------
  logic [7:0] otpCrc;
  logic [7:0] wrCrc;
  logic resetPulse;
  logic ctrlWrite;
  logic lockNow;
  logic [WR_BYTES-1:0][7:0] wrBlock;
  logic [7:0] statusByte;

  assign wrBlock = cfg_reg;
  assign lockNow = cfg_reg.device_config[INIT_LOCK_BIT];
  assign ctrlWrite = regValid && regWrite && (regAddr == ADDR_DEV_CTRL);

  // Serial bytes are part of the covered image
  acra_crc8 #(
    .NBYTES(OTP_BYTES)
  ) u_otp_crc (
    .blockData(shadow_reg),
    .crcValue(otpCrc)
  );

  // Independent checker for the writable block
  acra_crc8 #(
    .NBYTES(WR_BYTES)
  ) u_wr_crc (
    .blockData(wrBlock),
    .crcValue(wrCrc)
  );

  acra_reset_seq u_reset_seq (
    .clk(clk),
    .sys_rst(sys_rst),
    .cmdValid(regValid),
    .ctrlWrite(ctrlWrite),
    .resetCode({regWrData[RESET_CODE_HIGH_BIT], regWrData[RESET_CODE_LOW_BIT]}),
    .resetPulse(resetPulse)
  );

  // ----------------------------------------
  // Status byte: live inputs plus device-reset flag
  // ----------------------------------------
  always_comb begin
    statusByte = senseIn.status & STATUS_IN_MASK;
    statusByte[STATUS_DEVRES_BIT] = devResFlag_reg;
  end

  // ----------------------------------------
  // Shadow load and CRC monitors
  // ----------------------------------------
  always_comb begin
    shadow_next = shadow_reg;
    loadPending_next = 1'b0;
    otpFault_next = otpFault_reg;
    wrFault_next = wrFault_reg;
    wrCrcRef_next = wrCrcRef_reg;
    lockArmed_next = lockNow && !resetPulse;
    // Fuses copied once after reset; host writes never reach here
    if (loadPending_reg) begin
      shadow_next = otpImage;
    end else if (otpCrc != otpCrcRef) begin
      otpFault_next = 1'b1;
    end
    // Reference follows the block until a cycle after locking, so it covers the locking write
    if (!lockArmed_reg) begin
      wrCrcRef_next = wrCrc;
    end else if (wrCrc != wrCrcRef_reg) begin
      wrFault_next = 1'b1;
    end
    if (resetPulse) begin
      wrFault_next = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      shadow_reg <= '0;
      loadPending_reg <= 1'b1;
      otpFault_reg <= 1'b0;
      wrFault_reg <= 1'b0;
      wrCrcRef_reg <= CRC_INIT;
      lockArmed_reg <= 1'b0;
    end else begin
      shadow_reg <= shadow_next;
      loadPending_reg <= loadPending_next;
      otpFault_reg <= otpFault_next;
      wrFault_reg <= wrFault_next;
      wrCrcRef_reg <= wrCrcRef_next;
      lockArmed_reg <= lockArmed_next;
    end
  end

  // ----------------------------------------
  // Writable registers
  // ----------------------------------------
  always_comb begin
    cfg_next = cfg_reg;
    devResFlag_next = devResFlag_reg;
    if (regValid && !regWrite && (regAddr == ADDR_STATUS)) begin
      devResFlag_next = 1'b0;
    end
    // Locked block takes no writes; device control holds no storage
    if (regValid && regWrite && !lockNow) begin
      case (regAddr)
        ADDR_DEV_CFG: cfg_next.device_config = regWrData & DEV_CFG_WMASK;
        ADDR_AXIS_X: cfg_next.axisX = regWrData & AXIS_CFG_WMASK;
        ADDR_AXIS_Y: cfg_next.axisY = regWrData & AXIS_CFG_WMASK;
        ADDR_ARM_CFG_X: cfg_next.armX = regWrData & ARM_CFG_WMASK;
        ADDR_ARM_CFG_Y: cfg_next.armY = regWrData & ARM_CFG_WMASK;
        ADDR_THR_XP: cfg_next.thrXp = regWrData;
        ADDR_THR_YP: cfg_next.thrYp = regWrData;
        ADDR_THR_XN: cfg_next.thrXn = regWrData;
        ADDR_THR_YN: cfg_next.thrYn = regWrData;
        default: begin
        end
      endcase
    end
    // Device reset clears the lock and all configuration
    if (resetPulse) begin
      cfg_next = '0;
      devResFlag_next = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg_reg <= '0;
      devResFlag_reg <= 1'b1;
    end else begin
      cfg_reg <= cfg_next;
      devResFlag_reg <= devResFlag_next;
    end
  end

  // ----------------------------------------
  // Read decode and invalid-address reporting
  // ----------------------------------------
  always_comb begin
    ack_next = regValid;
    rdData_next = RESET_VALUE;
    invalid_next = 1'b0;
    if (regValid) begin
      case (regAddr)
        ADDR_SERIAL0, 8'h01, 8'h02, ADDR_SERIAL3: begin
          if (!regWrite) rdData_next = shadow_reg[regAddr[1:0]];
        end
        ADDR_RSVD_F04: begin
          if (!regWrite) rdData_next = shadow_reg[4];
        end
        ADDR_RSVD_F05: begin
          if (!regWrite) rdData_next = shadow_reg[5];
        end
        ADDR_FACT_X: begin
          if (!regWrite) rdData_next = shadow_reg[6];
        end
        ADDR_FACT_Y: begin
          if (!regWrite) rdData_next = shadow_reg[7];
        end
        ADDR_PART_CODE: begin
          if (!regWrite) rdData_next = shadow_reg[8];
        end
        ADDR_UNASSIGNED: invalid_next = 1'b1;
        ADDR_DEV_CTRL: rdData_next = RESET_VALUE;
        ADDR_DEV_CFG: begin
          if (!regWrite) rdData_next = cfg_reg.device_config;
        end
        ADDR_AXIS_X: begin
          if (!regWrite) rdData_next = cfg_reg.axisX;
        end
        ADDR_AXIS_Y: begin
          if (!regWrite) rdData_next = cfg_reg.axisY;
        end
        ADDR_ARM_CFG_X: begin
          if (!regWrite) rdData_next = cfg_reg.armX;
        end
        ADDR_ARM_CFG_Y: begin
          if (!regWrite) rdData_next = cfg_reg.armY;
        end
        ADDR_THR_XP: begin
          if (!regWrite) rdData_next = cfg_reg.thrXp;
        end
        ADDR_THR_YP: begin
          if (!regWrite) rdData_next = cfg_reg.thrYp;
        end
        ADDR_THR_XN: begin
          if (!regWrite) rdData_next = cfg_reg.thrXn;
        end
        ADDR_THR_YN: begin
          if (!regWrite) rdData_next = cfg_reg.thrYn;
        end
        ADDR_STATUS: begin
          if (!regWrite) rdData_next = statusByte;
        end
        ADDR_COUNTER: begin
          if (!regWrite) rdData_next = senseIn.counter;
        end
        ADDR_OFFSET_X: begin
          if (!regWrite) rdData_next = senseIn.offsetX;
        end
        ADDR_OFFSET_Y: begin
          if (!regWrite) rdData_next = senseIn.offsetY;
        end
        ADDR_RSVD_U1C, ADDR_RSVD_U1D: rdData_next = RESET_VALUE;
        default: invalid_next = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ack_reg <= 1'b0;
      rdData_reg <= RESET_VALUE;
      invalid_reg <= 1'b0;
    end else begin
      ack_reg <= ack_next;
      rdData_reg <= rdData_next;
      invalid_reg <= invalid_next;
    end
  end

  // ----------------------------------------
  // Per-axis self-test magnitude
  // ----------------------------------------
  genvar ax;
  generate
    for (ax = 0; ax < 2; ax++) begin : g_axis
      // Clear: low deflection up to 60 g; set: high deflection
      assign selftestHigh[ax] = shadow_reg[6 + ax][SELFTEST_MAG_BIT];
    end
  endgenerate

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign regAck = ack_reg;
  assign regRdData = rdData_reg;
  assign regInvalid = invalid_reg;
  assign cfgOut = cfg_reg;
  assign serialNumber = {shadow_reg[3], shadow_reg[2], shadow_reg[1], shadow_reg[0]};
  assign partCode = shadow_reg[8];
  assign initLocked = lockNow;
  assign otpCrcFault = otpFault_reg;
  assign wrCrcFault = wrFault_reg;
  assign deviceReset = resetPulse;

endmodule
`default_nettype wire

// ==== tb/acra_asserts.sv ====
// Port assertions of the customer register array
`timescale 1ns/1ns
`default_nettype none
module acra_asserts import acra_pkg::*; (
  input wire logic clk, // System clock
  input wire logic sys_rst, // Synchronous reset
  input wire logic regValid, // Command strobe
  input wire logic regWrite, // Write flag
  input wire logic [7:0] regAddr, // Address
  input wire logic regAck, // Answer strobe
  input wire logic [7:0] regRdData, // Read data
  input wire logic regInvalid, // Invalid request
  input wire acra_cfg_s cfgOut, // Configuration
  input wire logic [1:0] selftestHigh, // Magnitude select
  input wire logic [31:0] serialNumber, // Serial number
  input wire logic initLocked, // Lock
  input wire logic deviceReset // Device reset pulse
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_ack_follows_cmd: assert property (regValid |=> regAck) else $error("no answer to command");
  a_ack_only_cmd: assert property (!regValid |=> !regAck) else $error("answer without command");
  a_gap_addr_invalid: assert property (regValid && regAddr == ADDR_UNASSIGNED |=> regAck && regInvalid)
    else $error("gap address not flagged");
  a_high_addr_invalid: assert property (regValid && (regAddr inside {[8'h18:8'h1b]} || regAddr > 8'h1d)
    |=> regInvalid) else $error("unmapped address not flagged");
  a_factory_addr_valid: assert property (regValid && regAddr <= ADDR_PART_CODE |=> !regInvalid)
    else $error("factory address flagged");
  a_serial_low_byte: assert property (regValid && !regWrite && regAddr == ADDR_SERIAL0
    |=> regRdData == serialNumber[7:0]) else $error("serial low byte");
  a_serial_high_byte: assert property (regValid && !regWrite && regAddr == ADDR_SERIAL3
    |=> regRdData == serialNumber[31:24]) else $error("serial high byte");
  a_axis_magnitude: assert property (regValid && !regWrite && regAddr == ADDR_FACT_Y
    |=> regRdData[7] == selftestHigh[1]) else $error("magnitude bit");
  a_write_reads_zero: assert property (regValid && regWrite |=> regRdData == 8'h00) else $error("write data");
  a_lock_holds_cfg: assert property (initLocked && !deviceReset |=> $stable(cfgOut) && initLocked)
    else $error("locked config changed");
  a_reset_clears_cfg: assert property (deviceReset |=> cfgOut == '0 && !initLocked && !deviceReset)
    else $error("device reset");

  c_invalid: cover property (regAck && regInvalid);
  c_dev_reset: cover property (deviceReset);
  c_locked: cover property ($rose(initLocked));
endmodule
`default_nettype wire

// ==== tb/acra_host.sv ====
// Host side model issuing register commands
`timescale 1ns/1ns
`default_nettype none
module acra_host (
  input wire logic clk, // System clock
  input wire logic regAck, // Answer strobe
  input wire logic regInvalid, // Invalid request
  input wire logic [7:0] regRdData, // Read data
  output logic regValid, // Command strobe
  output logic regWrite, // Write flag
  output logic [7:0] regAddr, // Address
  output logic [7:0] regWrData // Write data
);
  initial begin
    regValid = 1'b0;
    regWrite = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
  end

  // One-cycle strobe; qualifiers turn to junk once released
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] rd, output logic inv);
    int n;
    n = 0;
    @(negedge clk);
    regValid = 1'b1;
    regWrite = w;
    regAddr = a;
    regWrData = d;
    @(negedge clk);
    regValid = 1'b0;
    regWrite = ~w;
    regAddr = ~a;
    regWrData = ~d;
    while (regAck !== 1'b1 && n < 4) begin
      @(negedge clk);
      n++;
    end
    rd = (regAck === 1'b1) ? regRdData : 8'hxx;
    inv = (regAck === 1'b1) ? regInvalid : 1'bx;
  endtask
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking testbench of the customer register array
`timescale 1ns/1ns
`default_nettype none
module tb_top import acra_pkg::*;;
  logic clk, sys_rst, regValid, regWrite, regAck, regInvalid, initLocked, otpCrcFault, wrCrcFault, deviceReset, inv;
  logic [7:0] regAddr, regWrData, regRdData, otpCrcRef, partCode, rd;
  logic [OTP_BYTES-1:0][7:0] otpImage;
  acra_sense_s senseIn;
  acra_cfg_s cfgOut;
  logic [1:0] selftestHigh;
  logic [31:0] serialNumber;
  int n_fail, check_count, nRst;

  acra_register_array dut (.clk(clk), .sys_rst(sys_rst), .otpImage(otpImage), .otpCrcRef(otpCrcRef),
    .senseIn(senseIn), .regValid(regValid), .regWrite(regWrite), .regAddr(regAddr), .regWrData(regWrData),
    .regAck(regAck), .regRdData(regRdData), .regInvalid(regInvalid), .cfgOut(cfgOut),
    .selftestHigh(selftestHigh), .serialNumber(serialNumber), .partCode(partCode), .initLocked(initLocked),
    .otpCrcFault(otpCrcFault), .wrCrcFault(wrCrcFault), .deviceReset(deviceReset));
  acra_host host (.clk(clk), .regAck(regAck), .regInvalid(regInvalid), .regRdData(regRdData),
    .regValid(regValid), .regWrite(regWrite), .regAddr(regAddr), .regWrData(regWrData));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) if (deviceReset === 1'b1) nRst++;

  function automatic logic [7:0] crc8(logic [OTP_BYTES-1:0][7:0] b);
    logic [7:0] c;
    c = 8'hff;
    for (int i = 0; i < OTP_BYTES; i++) begin
      c = c ^ b[i];
      for (int j = 0; j < 8; j++) c = c[7] ? ({c[6:0], 1'b0} ^ 8'h2f) : {c[6:0], 1'b0};
    end
    return c;
  endfunction

  task chk(string nm, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task stop_test;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task rst5;
    sys_rst = 1'b1;
    repeat (5) @(negedge clk);
    sys_rst = 1'b0;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_factory;
    for (int i = 0; i < OTP_BYTES; i++) begin
      host.xfer(1'b1, i[7:0], 8'hff, rd, inv);
      host.xfer(1'b0, i[7:0], 8'h00, rd, inv);
      chk("factory byte", rd, otpImage[i]);
    end
    chk("serial", serialNumber, 32'h1234_5abc);
    chk("magnitude", selftestHigh, 2'b01);
    chk("part", partCode, 8'h1a);
    chk("otp fault", otpCrcFault, 1'b0);
  endtask

  task t_map;
    logic [7:0] bad[5];
    bad = '{8'h09, 8'h18, 8'h1b, 8'h1e, 8'hff};
    foreach (bad[i]) begin
      host.xfer(1'b0, bad[i], 8'h00, rd, inv);
      chk("invalid", inv, 1'b1);
    end
    host.xfer(1'b0, ADDR_RSVD_U1C, 8'h00, rd, inv);
    chk("upper reserved", {inv, rd}, 9'h000);
  endtask

  task t_rw;
    logic [7:0] m;
    chk("cfg reset", |cfgOut, 1'b0);
    for (int a = 8'h0c; a <= 8'h13; a++) begin
      m = (a < 8'h0e) ? AXIS_CFG_WMASK : (a < 8'h10) ? ARM_CFG_WMASK : 8'hff;
      host.xfer(1'b1, a[7:0], a[7:0] ^ 8'hf3, rd, inv);
      host.xfer(1'b0, a[7:0], 8'h00, rd, inv);
      chk("rw byte", rd, (a[7:0] ^ 8'hf3) & m);
    end
    host.xfer(1'b1, ADDR_COUNTER, 8'h00, rd, inv);
    host.xfer(1'b0, ADDR_COUNTER, 8'h00, rd, inv);
    chk("counter", rd, 8'h3c);
  endtask

  task t_lock;
    host.xfer(1'b1, ADDR_DEV_CFG, 8'h3f, rd, inv);
    chk("locked", initLocked, 1'b1);
    host.xfer(1'b1, ADDR_THR_XP, 8'h00, rd, inv);
    host.xfer(1'b0, ADDR_THR_XP, 8'h00, rd, inv);
    chk("locked byte", rd, 8'he3);
    chk("wr fault", wrCrcFault, 1'b0);
  endtask

  task t_reset_seq;
    host.xfer(1'b0, ADDR_STATUS, 8'h00, rd, inv);
    chk("status set", rd, 8'h7f);
    host.xfer(1'b0, ADDR_STATUS, 8'h00, rd, inv);
    chk("status clear", rd, 8'h7e);
    host.xfer(1'b1, ADDR_DEV_CTRL, 8'h00, rd, inv);
    host.xfer(1'b1, ADDR_DEV_CTRL, 8'hc0, rd, inv);
    host.xfer(1'b0, ADDR_DEV_CTRL, 8'h00, rd, inv);
    chk("ctrl read", rd, 8'h00);
    host.xfer(1'b1, ADDR_DEV_CTRL, 8'h40, rd, inv);
    @(negedge clk);
    chk("aborted", nRst, 0);
    host.xfer(1'b1, ADDR_DEV_CTRL, 8'h00, rd, inv);
    host.xfer(1'b1, ADDR_DEV_CTRL, 8'hc0, rd, inv);
    host.xfer(1'b1, ADDR_DEV_CTRL, 8'h40, rd, inv);
    repeat (3) @(negedge clk);
    chk("reset count", nRst, 1);
    chk("unlocked", {initLocked, |cfgOut}, 2'b00);
    host.xfer(1'b0, ADDR_STATUS, 8'h00, rd, inv);
    chk("status reset", rd, 8'h7f);
  endtask

  task t_crc;
    @(negedge clk);
    otpCrcRef = ~otpCrcRef;
    repeat (4) @(negedge clk);
    chk("otp fault set", {otpCrcFault, wrCrcFault}, 2'b10);
    otpCrcRef = ~otpCrcRef;
    rst5();
    repeat (3) @(negedge clk);
    chk("otp fault clear", otpCrcFault, 1'b0);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    n_fail = 0;
    check_count = 0;
    nRst = 0;
    otpImage = {8'h1a, 8'h01, 8'h81, 8'h5a, 8'ha5, 8'h12, 8'h34, 8'h5a, 8'hbc};
    otpCrcRef = crc8(otpImage);
    senseIn = '{counter: 8'h3c, offsetX: 8'h11, offsetY: 8'h22, status: 8'hff};
    rst5();
    repeat (2) @(negedge clk);
    t_factory();
    t_map();
    t_rw();
    t_lock();
    t_reset_seq();
    t_crc();
    stop_test();
  end

  initial begin
    #100000;
    n_fail++;
    stop_test();
  end
endmodule

bind acra_register_array acra_asserts chk_i (.clk(clk), .sys_rst(sys_rst), .regValid(regValid),
  .regWrite(regWrite), .regAddr(regAddr), .regAck(regAck), .regRdData(regRdData), .regInvalid(regInvalid),
  .cfgOut(cfgOut), .selftestHigh(selftestHigh), .serialNumber(serialNumber), .initLocked(initLocked),
  .deviceReset(deviceReset));
`default_nettype wire
